// *** hw/eeprom_host.sv ***
// Host controller driving a byte-wide parallel EEPROM through its strobes
//
// Summary of operation
// - Write: chip select low, enable high, strobe low
// - Erase: select, strobe low, enable at high voltage
// - Hold erase condition at least ten milliseconds
// - Same page bits on every strobe fall
// - Output enable high while loading page bytes
// - Next page byte within 150 microseconds
// - Write pulse low at least 100 ns
// - Write pulse high at least 50 ns
`timescale 1ns/1ps
`default_nettype none
module eeprom_host
   import eeprom_host_pkg::*;
#(
   parameter int PROGRAM_CYCLES = PROGRAM_CYCLE_CYC,
   parameter int FAST_PROGRAM_CYCLES = FAST_PROGRAM_CYCLE_CYC,
   parameter int ERASE_CYCLES = ERASE_PULSE_CYC
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Command port
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire op_type cmd_op,
   input wire logic [ADDR_W-1:0] cmd_addr,
   // Page buffer load port
   input wire logic load_valid,
   output logic load_ready,
   input wire logic [BYTE_IDX_W-1:0] load_idx,
   input wire logic [DATA_W-1:0] load_data,
   // Read answer, status and fast write mode
   output logic rd_valid,
   output logic [DATA_W-1:0] rd_data,
   output logic busy,
   input wire logic fast_write,
   // Device pins
   output logic [ADDR_W-1:0] mem_addr,
   output logic mem_ce_n,
   output logic mem_oe_n,
   output logic mem_we_n,
   input wire logic [DATA_W-1:0] mem_data_in,
   output logic [DATA_W-1:0] mem_data_out,
   output logic mem_data_oe_n,
   output logic erase_hv_en
);

   typedef enum logic [3:0] {
      S_IDLE,
      S_RD_WAIT,
      S_RD_FLOAT,
      S_SCAN,
      S_CHECK,
      S_WR_LOW,
      S_WR_HIGH,
      S_FINISH,
      S_PROG_WAIT,
      S_ER_SETUP,
      S_ER_PULSE,
      S_ER_HOLD
   } state_type;

   typedef struct packed {
      state_type state;
      logic [COUNT_W-1:0] cnt;
      logic [BYTE_IDX_W-1:0] idx;
      logic [PAGE_W-1:0] page;
      logic any_loaded;
      logic rd_valid;
      logic [DATA_W-1:0] rd_data;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data_out;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic data_oe_n;
      logic hv;
   } host_state_type;

   host_state_type s_q;
   host_state_type s_d;
   logic cnt_done;
   logic streaming;

   page_buf_if buf_bus ();

   page_buffer u_page_buffer (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .buf_port(buf_bus.store)
   );

   // Handshakes are combinational; loads pause only while the page streams out
   assign cnt_done = (s_q.cnt == '0);
   assign streaming = (s_q.state == S_SCAN) || (s_q.state == S_CHECK) ||
                      (s_q.state == S_WR_LOW) || (s_q.state == S_WR_HIGH) ||
                      (s_q.state == S_FINISH);
   assign cmd_ready = (s_q.state == S_IDLE);
   assign load_ready = !streaming;
   assign buf_bus.wr_en = load_valid && load_ready;
   assign buf_bus.wr_idx = load_idx;
   assign buf_bus.wr_data = load_data;
   assign buf_bus.rd_idx = s_q.idx;
   assign buf_bus.clear = (s_q.state == S_FINISH);

   // Sequencer: each timed phase is one state, counter counts down to zero
   always_comb
   begin
      s_d = s_q;
      s_d.rd_valid = 1'b0;
      if (!cnt_done)
      begin
         s_d.cnt = s_q.cnt - COUNT_W'(1);
      end
      unique case (s_q.state)
         S_IDLE:
         begin
            // Deselected: standby, nothing on the bus from either side
            s_d.ce_n = 1'b1;
            s_d.oe_n = 1'b1;
            s_d.we_n = 1'b1;
            s_d.data_oe_n = 1'b1;
            if (cmd_valid)
            begin
               case (cmd_op)
                  OP_READ:
                  begin
                     s_d.addr = cmd_addr;
                     s_d.ce_n = 1'b0;
                     s_d.oe_n = 1'b0;
                     s_d.cnt = COUNT_W'(READ_ACCESS_CYC - 1);
                     s_d.state = S_RD_WAIT;
                  end
                  OP_PAGE_WRITE:
                  begin
                     // Page bits are latched once for the whole load
                     s_d.page = cmd_addr[ADDR_W-1:BYTE_IDX_W];
                     s_d.idx = FIRST_BYTE_IDX;
                     s_d.any_loaded = 1'b0;
                     s_d.ce_n = 1'b0;
                     s_d.state = S_SCAN;
                  end
                  OP_CHIP_ERASE:
                  begin
                     s_d.ce_n = 1'b0;
                     s_d.hv = 1'b1;
                     s_d.cnt = COUNT_W'(ERASE_EDGE_CYC - 1);
                     s_d.state = S_ER_SETUP;
                  end
                  default:
                  begin
                     s_d.state = S_IDLE;
                  end
               endcase
            end
         end
         S_RD_WAIT:
         begin
            if (cnt_done)
            begin
               // During programming this byte carries the polling bits
               s_d.rd_data = mem_data_in;
               s_d.rd_valid = 1'b1;
               s_d.ce_n = 1'b1;
               s_d.oe_n = 1'b1;
               s_d.cnt = COUNT_W'(OUTPUT_FLOAT_CYC - 1);
               s_d.state = S_RD_FLOAT;
            end
         end
         S_RD_FLOAT:
         begin
            // Let the device release the bus before anyone drives it
            if (cnt_done)
            begin
               s_d.state = S_IDLE;
            end
         end
         S_SCAN:
         begin
            // Buffer read address is idx; its data arrive next cycle
            s_d.state = S_CHECK;
         end
         S_CHECK:
         begin
            if (buf_bus.rd_loaded)
            begin
               // Only loaded slots are strobed; output enable stays high
               s_d.addr = {s_q.page, s_q.idx};
               s_d.data_out = buf_bus.rd_data;
               s_d.data_oe_n = 1'b0;
               s_d.oe_n = 1'b1;
               s_d.we_n = 1'b0;
               s_d.any_loaded = 1'b1;
               s_d.cnt = COUNT_W'(WRITE_PULSE_CYC - 1);
               s_d.state = S_WR_LOW;
            end
            else if (s_q.idx == LAST_BYTE_IDX)
            begin
               s_d.state = S_FINISH;
            end
            else
            begin
               s_d.idx = s_q.idx + BYTE_IDX_W'(1);
               s_d.state = S_SCAN;
            end
         end
         S_WR_LOW:
         begin
            if (cnt_done)
            begin
               s_d.we_n = 1'b1;
               s_d.cnt = COUNT_W'(WRITE_HIGH_CYC - 1);
               s_d.state = S_WR_HIGH;
            end
         end
         S_WR_HIGH:
         begin
            // Bytes follow within a few hundred cycles, far inside the window
            if (cnt_done)
            begin
               s_d.data_oe_n = 1'b1;
               if (s_q.idx == LAST_BYTE_IDX)
               begin
                  s_d.state = S_FINISH;
               end
               else
               begin
                  s_d.idx = s_q.idx + BYTE_IDX_W'(1);
                  s_d.state = S_SCAN;
               end
            end
         end
         S_FINISH:
         begin
            // Raising chip select and waiting lets the window lapse
            s_d.ce_n = 1'b1;
            if (s_q.any_loaded)
            begin
               s_d.cnt = fast_write ? COUNT_W'(FAST_PROGRAM_CYCLES - 1) :
                                      COUNT_W'(PROGRAM_CYCLES - 1);
               s_d.state = S_PROG_WAIT;
            end
            else
            begin
               s_d.state = S_IDLE;
            end
         end
         S_PROG_WAIT:
         begin
            // No access until the worst-case programming time has passed
            if (cnt_done)
            begin
               s_d.state = S_IDLE;
            end
         end
         S_ER_SETUP:
         begin
            if (cnt_done)
            begin
               s_d.we_n = 1'b0;
               s_d.cnt = COUNT_W'(ERASE_CYCLES - 1);
               s_d.state = S_ER_PULSE;
            end
         end
         S_ER_PULSE:
         begin
            if (cnt_done)
            begin
               s_d.we_n = 1'b1;
               s_d.cnt = COUNT_W'(ERASE_EDGE_CYC - 1);
               s_d.state = S_ER_HOLD;
            end
         end
         S_ER_HOLD:
         begin
            if (cnt_done)
            begin
               s_d.hv = 1'b0;
               s_d.ce_n = 1'b1;
               s_d.state = S_IDLE;
            end
         end
      endcase
   end

   // All control state resets to an idle, deselected bus
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         s_q <= '0;
         s_q.state <= S_IDLE;
         s_q.ce_n <= 1'b1;
         s_q.oe_n <= 1'b1;
         s_q.we_n <= 1'b1;
         s_q.data_oe_n <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Pin and answer outputs straight from flops
   assign rd_valid = s_q.rd_valid;
   assign rd_data = s_q.rd_data;
   assign busy = (s_q.state != S_IDLE);
   assign mem_addr = s_q.addr;
   assign mem_ce_n = s_q.ce_n;
   assign mem_oe_n = s_q.oe_n;
   assign mem_we_n = s_q.we_n;
   assign mem_data_out = s_q.data_out;
   assign mem_data_oe_n = s_q.data_oe_n;
   assign erase_hv_en = s_q.hv;

endmodule : eeprom_host
`default_nettype wire

// *** hw/eeprom_host_pkg.sv ***
// Constants and types shared by the parallel EEPROM host controller files
package eeprom_host_pkg;

   // Clock rate of clk_sys
   localparam int CLK_MHZ = 100;

   // Pin and page geometry
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam int BYTE_IDX_W = 6;
   localparam int PAGE_W = ADDR_W - BYTE_IDX_W;
   localparam int PAGE_BYTES = 64;
   localparam logic [BYTE_IDX_W-1:0] LAST_BYTE_IDX = 6'h3f;
   localparam logic [BYTE_IDX_W-1:0] FIRST_BYTE_IDX = 6'h00;

   // Times in their printed units
   localparam int WRITE_PULSE_NS = 100;
   localparam int WRITE_HIGH_NS = 50;
   localparam int READ_ACCESS_NS = 150;
   localparam int OUTPUT_FLOAT_NS = 50;
   localparam int BYTE_LOAD_WINDOW_US = 150;
   localparam int PROGRAM_CYCLE_MS = 10;
   localparam int FAST_PROGRAM_CYCLE_MS = 2;
   localparam int ERASE_PULSE_MS = 10;
   localparam int ERASE_EDGE_US = 1;

   // Least times round up to whole cycles
   localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int WRITE_HIGH_CYC = (WRITE_HIGH_NS * CLK_MHZ + 999) / 1000;
   localparam int READ_ACCESS_CYC = (READ_ACCESS_NS * CLK_MHZ + 999) / 1000;
   localparam int OUTPUT_FLOAT_CYC = (OUTPUT_FLOAT_NS * CLK_MHZ + 999) / 1000;
   localparam int ERASE_EDGE_CYC = ERASE_EDGE_US * CLK_MHZ;
   localparam int ERASE_PULSE_CYC = ERASE_PULSE_MS * 1000 * CLK_MHZ;
   // Device maxima that the host must wait out, so the wait is the full figure
   localparam int PROGRAM_CYCLE_CYC = PROGRAM_CYCLE_MS * 1000 * CLK_MHZ;
   localparam int FAST_PROGRAM_CYCLE_CYC = FAST_PROGRAM_CYCLE_MS * 1000 * CLK_MHZ;
   // Longest gap between page bytes rounds down
   localparam int BYTE_LOAD_WINDOW_CYC = BYTE_LOAD_WINDOW_US * CLK_MHZ;

   // Down counter wide enough for the longest wait
   localparam int COUNT_W = 21;

   // Host commands
   typedef enum logic [1:0] {
      OP_READ,
      OP_PAGE_WRITE,
      OP_CHIP_ERASE
   } op_type;

endpackage : eeprom_host_pkg

// *** hw/page_buf_if.sv ***
// Connection between the controller and its page buffer
`timescale 1ns/1ps
`default_nettype none
interface page_buf_if;
   import eeprom_host_pkg::*;
   logic wr_en;
   logic [BYTE_IDX_W-1:0] wr_idx;
   logic [DATA_W-1:0] wr_data;
   logic clear;
   logic [BYTE_IDX_W-1:0] rd_idx;
   logic [DATA_W-1:0] rd_data;
   logic rd_loaded;

   modport owner (
      output wr_en, wr_idx, wr_data, clear, rd_idx,
      input rd_data, rd_loaded
   );
   modport store (
      input wr_en, wr_idx, wr_data, clear, rd_idx,
      output rd_data, rd_loaded
   );
endinterface : page_buf_if
`default_nettype wire

// *** hw/page_buffer.sv ***
// Page buffer: one byte and one loaded flag per byte slot, registered read
`timescale 1ns/1ps
`default_nettype none
module page_buffer
   import eeprom_host_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Controller side
   page_buf_if.store buf_port
);

   typedef struct packed {
      logic [PAGE_BYTES-1:0][DATA_W-1:0] mem;
      logic [PAGE_BYTES-1:0] loaded;
      logic [DATA_W-1:0] rd_data;
      logic rd_loaded;
   } buf_state_type;

   buf_state_type s_q;
   buf_state_type s_d;

   // Clear comes first so a write in the same cycle still marks its slot
   always_comb
   begin
      s_d = s_q;
      if (buf_port.clear)
      begin
         s_d.loaded = '0;
      end
      if (buf_port.wr_en)
      begin
         s_d.mem[buf_port.wr_idx] = buf_port.wr_data;
         s_d.loaded[buf_port.wr_idx] = 1'b1;
      end
      s_d.rd_data = s_q.mem[buf_port.rd_idx];
      s_d.rd_loaded = s_q.loaded[buf_port.rd_idx];
   end

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign buf_port.rd_data = s_q.rd_data;
   assign buf_port.rd_loaded = s_q.rd_loaded;

endmodule : page_buffer
`default_nettype wire

// *** verification/eeprom_model.sv ***
// Behavioural model of the byte-wide parallel EEPROM on the controller's far side
`timescale 1ns/1ps
`default_nettype none
module eeprom_model #(
   parameter int ERASE_NS = 500,
   // Load window and program time, shortened so the bench stays small
   parameter int WINDOW_NS = 1500,
   parameter int PROG_NS = 500
)
(
   // Strobes
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic hv,
   // Address and data
   input wire logic [12:0] addr,
   input wire logic [7:0] din,
   output logic [7:0] dout,
   output logic drive
);
   logic [7:0] mem [0:8191];
   logic [12:0] last_a = 13'h0000;
   logic [7:0] last_d = 8'h00;
   logic busy_q = 1'b0;
   logic tog_q = 1'b0;
   realtime t_fall;
   realtime t_we;

   // Array starts erased, with no byte loaded yet
   initial
   begin
      t_fall = 0.0;
      t_we = -1.0e9;
      for (int i = 0; i < 8192; i++) mem[i] = 8'hff;
   end

   // Drives the bus only in read mode, so standby and erase leave it floating
   assign drive = !ce_n && !oe_n && we_n && !hv;
   // While a page loads or programs, reads poll: last byte's top bit inverted, bit six toggling
   assign dout = !busy_q ? mem[addr] :
      {(addr == last_a) ? ~last_d[7] : mem[addr][7], tog_q, mem[addr][5:0]};

   // Load window plus self-timed program cycle, stepped between clock edges
   always
   begin
      #10;
      busy_q = ($realtime - t_we) < (WINDOW_NS + PROG_NS);
   end

   // Each read strobe that ends during programming flips the toggle bit
   always @(posedge oe_n) if (busy_q) tog_q = ~tog_q;

   always @(negedge we_n) t_fall = $realtime;

   // Byte taken at the strobe's rising edge; a write changes only the addressed byte, an erase sets every byte
   always @(posedge we_n)
   begin
      if (!ce_n && hv && ($realtime - t_fall) >= ERASE_NS)
      begin
         for (int i = 0; i < 8192; i++) mem[i] = 8'hff;
      end
      // Once the window lapses, bytes are refused until programming ends
      else if (!ce_n && oe_n && !hv && (($realtime - t_we) < WINDOW_NS ||
         ($realtime - t_we) >= WINDOW_NS + PROG_NS))
      begin
         mem[addr] = din;
         last_a = addr;
         last_d = din;
         t_we = $realtime;
      end
   end
endmodule : eeprom_model
`default_nettype wire

// *** verification/eeprom_host_checker.sv ***
// Pin-level assertions on the EEPROM host controller
`timescale 1ns/1ps
`default_nettype none
module eeprom_host_checker
   import eeprom_host_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Device pins and read answer valid
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic mem_ce_n,
   input wire logic mem_oe_n,
   input wire logic mem_we_n,
   input wire logic mem_data_oe_n,
   input wire logic erase_hv_en,
   input wire logic rd_valid
);
   logic have_q;
   logic [PAGE_W-1:0] page_q;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   // Each strobe of a selected burst latches its page for the next strobe to match
   always_ff @(posedge clk_sys)
   begin
      if (!resetn || mem_ce_n)
      begin
         have_q <= 1'b0;
         page_q <= '0;
      end
      else if ($fell(mem_we_n))
      begin
         have_q <= 1'b1;
         page_q <= mem_addr[ADDR_W-1:BYTE_IDX_W];
      end
   end

   AST_OE_INHIBITS_WE: assert property (!mem_oe_n |-> mem_we_n)
      else $error("write strobe low while output enable low");
   AST_NO_CONTENTION: assert property (!mem_data_oe_n |-> mem_oe_n)
      else $error("host drives data while device may drive");
   AST_WE_NEEDS_CE: assert property (!mem_we_n |-> !mem_ce_n)
      else $error("write strobe low without chip select");
   AST_WE_LOW_WIDTH: assert property ($fell(mem_we_n) |-> !mem_we_n [*8] ##1 !mem_we_n [*2])
      else $error("write pulse too short");
   AST_WE_HIGH_WIDTH: assert property ($rose(mem_we_n) |-> mem_we_n [*5])
      else $error("write pulse high time too short");
   AST_PAGE_SAME: assert property ($fell(mem_we_n) && have_q |->
      mem_addr[ADDR_W-1:BYTE_IDX_W] == page_q)
      else $error("page bits changed within a page load");
   AST_READ_TIMING: assert property ($fell(mem_oe_n) |->
      (!mem_oe_n && !mem_ce_n) [*8] ##1 !mem_oe_n [*7] ##1 (rd_valid && mem_oe_n))
      else $error("read strobe length or answer wrong");
   AST_ERASE_PINS: assert property (erase_hv_en |-> mem_oe_n && mem_data_oe_n)
      else $error("erase with output enable low or data driven");
   AST_PAGE_OE_HIGH: assert property (!mem_we_n && !mem_ce_n |-> mem_oe_n)
      else $error("output enable low during page load");
endmodule : eeprom_host_checker
`default_nettype wire

bind eeprom_host eeprom_host_checker chk_u (.clk_sys, .resetn, .mem_addr, .mem_ce_n,
   .mem_oe_n, .mem_we_n, .mem_data_oe_n, .erase_hv_en, .rd_valid);

// *** verification/tb_top.sv ***
// Self-checking testbench for the EEPROM host controller with a device model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import eeprom_host_pkg::*;
   // Program waits must outlast the model's load window plus program time
   localparam int PROG_C = 300;
   localparam int FAST_C = 200;
   localparam int ERASE_C = 50;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic cmd_valid = 1'b0;
   logic load_valid = 1'b0;
   logic fast_write = 1'b0;
   op_type cmd_op = OP_READ;
   logic [ADDR_W-1:0] cmd_addr = 13'h0000;
   logic [BYTE_IDX_W-1:0] load_idx = 6'h00;
   logic [DATA_W-1:0] load_data = 8'h00;
   logic cmd_ready, load_ready, rd_valid, busy, mem_ce_n, mem_oe_n, mem_we_n;
   logic mem_data_oe_n, erase_hv_en, dev_drive;
   logic [DATA_W-1:0] rd_data, mem_data_in, mem_data_out, dev_dout;
   logic [DATA_W-1:0] last_bus = 8'h00;
   logic [ADDR_W-1:0] mem_addr;
   int error_cnt = 0;
   int n_tests = 0;
   int hi;

   always #5 clk_sys = ~clk_sys;

   // A released bus has no pull, so it shows the inverse of its last level
   always @(posedge clk_sys) last_bus <= resetn ? mem_data_in : 8'h00;
   assign mem_data_in = !mem_data_oe_n ? mem_data_out : dev_drive ? dev_dout : ~last_bus;

   eeprom_host #(.PROGRAM_CYCLES(PROG_C), .FAST_PROGRAM_CYCLES(FAST_C),
      .ERASE_CYCLES(ERASE_C)) dut_u (.clk_sys, .resetn, .cmd_valid, .cmd_ready, .cmd_op,
      .cmd_addr, .load_valid, .load_ready, .load_idx, .load_data, .rd_valid, .rd_data,
      .busy, .fast_write, .mem_addr, .mem_ce_n, .mem_oe_n, .mem_we_n, .mem_data_in,
      .mem_data_out, .mem_data_oe_n, .erase_hv_en);

   eeprom_model #(.ERASE_NS(ERASE_C * 10)) dev_u (.ce_n(mem_ce_n), .oe_n(mem_oe_n),
      .we_n(mem_we_n), .hv(erase_hv_en), .addr(mem_addr), .din(mem_data_out),
      .dout(dev_dout), .drive(dev_drive));

   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task end_sim;
      $display("Checks %0d, errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_sim

   // Waits for idle; counts busy cycles with the chip deselected (programming wait)
   task wait_idle(output int dead);
      int n;
      dead = 0;
      for (n = 0; n < 3000 && busy !== 1'b0; n++)
      begin
         if (mem_ce_n === 1'b1) dead++;
         @(posedge clk_sys);
         #1;
      end
      if (n == 3000)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: controller stuck busy", $time);
         end_sim();
      end
   endtask : wait_idle

   task cmd(input op_type op, input logic [ADDR_W-1:0] a);
      int d;
      wait_idle(d);
      cmd_op = op;
      cmd_addr = a;
      cmd_valid = 1'b1;
      @(posedge clk_sys);
      #1;
      cmd_valid = 1'b0;
      @(posedge clk_sys);
      #1;
   endtask : cmd

   // Gap between loads keeps the strobe from being re-raised in one step
   task load(input logic [BYTE_IDX_W-1:0] idx, input logic [DATA_W-1:0] d);
      load_valid = 1'b1;
      load_idx = idx;
      load_data = d;
      @(posedge clk_sys);
      #1;
      load_valid = 1'b0;
      @(posedge clk_sys);
      #1;
   endtask : load

   task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      int n;
      cmd(OP_READ, a);
      for (n = 1; n < 40 && rd_valid !== 1'b1; n++)
      begin
         @(posedge clk_sys);
         #1;
      end
      chk(16'(n), 16'(READ_ACCESS_CYC));
      chk(16'(rd_data), 16'(exp));
   endtask : rd

   task t_page_fast;
      fast_write = 1'b1;
      load(6'h03, 8'h5a);
      load(6'h3e, 8'h11);
      load(6'h03, 8'ha5);
      cmd(OP_PAGE_WRITE, 13'h0140);
      chk(16'({load_ready, busy, cmd_ready}), 16'h0002);
      wait_idle(hi);
      chk(16'(hi >= FAST_C && hi < PROG_C), 16'h0001);
      rd(13'h0143, 8'ha5);
      rd(13'h017e, 8'h11);
      rd(13'h0144, 8'hff);
   endtask : t_page_fast

   task t_erase;
      cmd(OP_CHIP_ERASE, 13'h0000);
      wait_idle(hi);
      rd(13'h0143, 8'hff);
   endtask : t_erase

   task t_page_slow;
      fast_write = 1'b0;
      load(6'h00, 8'h3c);
      cmd(OP_PAGE_WRITE, 13'h1fc0);
      wait_idle(hi);
      chk(16'(hi >= PROG_C), 16'h0001);
      rd(13'h1fc0, 8'h3c);
      rd(13'h1fc1, 8'hff);
   endtask : t_page_slow

   task t_bad_op;
      cmd(op_type'(2'd3), 13'h0000);
      chk(16'({busy, cmd_ready, mem_ce_n}), 16'h0003);
   endtask : t_bad_op

   // Main sequence: reset, then each scenario in turn
   initial
   begin
      repeat (8) @(posedge clk_sys);
      #1;
      chk(16'({mem_ce_n, mem_oe_n, mem_we_n, mem_data_oe_n, erase_hv_en, busy, cmd_ready,
         load_ready, rd_valid}), 16'h01e6);
      resetn = 1'b1;
      t_page_fast();
      t_erase();
      t_page_slow();
      t_bad_op();
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
